// ===== common/pm_link_if.sv
// links the controller to its watchdog counter and wake-up delay timer
`timescale 1ns/10ps
`default_nettype none
interface pm_link_if;
   logic wdog_enable;
   logic wdog_clear;
   logic wdog_ovf;
   logic dly_start;
   logic dly_powerup;
   logic dly_pll;
   logic dly_xtal;
   logic startup_ok;
   logic lock_ok;
   logic dly_done;
   modport ctl(output wdog_enable, wdog_clear, dly_start, dly_powerup,
      dly_pll, dly_xtal, startup_ok, lock_ok, input wdog_ovf, dly_done);
   modport wdog(input wdog_enable, wdog_clear, output wdog_ovf);
   modport dly(input dly_start, dly_powerup, dly_pll, dly_xtal,
      startup_ok, lock_ok, output dly_done);
endinterface
`default_nettype wire

// ===== common/pm_pkg.sv
// shared constants and types of the power-save and watchdog control
package pm_pkg;
   localparam int CLK_NS = 50;
   localparam int POR_NS = 10000;
   localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
   localparam int POWERUP_US = 1000;
   localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int LOCK_US = 20;
   localparam int LOCK_CYC = (LOCK_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int DLY_W = 16;
   localparam int WDOG_W = 16;
   localparam logic [WDOG_W-1:0] WDOG_TOP_DEF = 16'hffff;
   localparam int REG_W = 16;
   localparam int CFG_W = 24;
   localparam logic [CFG_W-1:0] CFG_MASK = 24'h00ffff;
   localparam logic [CFG_W-1:0] ADDR_OSC_CFG = 24'hf80000;
   localparam logic [CFG_W-1:0] ADDR_WDOG_CFG = 24'hf80002;
   localparam logic [CFG_W-1:0] ADDR_BROWNOUT_CFG = 24'hf80004;
   localparam logic [CFG_W-1:0] ADDR_CODESEG_CFG = 24'hf8000a;
   // reset control register fields
   localparam int B_IDLE = 2;
   localparam int B_SLEEP = 3;
   localparam int B_TIMEOUT = 4;
   localparam int B_SOFT_EN = 5;
   localparam int B_LEVEL_LO = 8;
   localparam int LEVEL_W = 4;
   localparam int B_DET_EN = 12;
   localparam int B_BANDGAP = 13;
   // fuse fields
   localparam int F_WDOG_EN = 7;
   localparam int F_PRIMODE_LO = 0;
   localparam int F_FAMILY_LO = 8;
   localparam int F_CLKSW = 14;
   localparam int F_CLKMON = 15;
   localparam int F_BROWNOUT_EN = 7;
   localparam int F_POWERUP_EN = 5;
   // oscillator sources and primary modes
   localparam logic [1:0] SRC_LOWXTAL = 2'h0;
   localparam logic [1:0] SRC_FASTRC = 2'h1;
   localparam logic [1:0] SRC_SLOWRC = 2'h2;
   localparam logic [1:0] SRC_PRIMARY = 2'h3;
   localparam logic [1:0] PRIMODE_EXT = 2'h0;
   localparam logic MODE_SLEEP = 1'b0;
   // synchronised inputs
   localparam int SYNC_N = 4;
   localparam int S_STARTUP = 0;
   localparam int S_LOCK = 1;
   localparam int S_RUNNING = 2;
   localparam int S_BANDGAP = 3;
   typedef enum logic [4:0] {
      ST_RUN = 5'h01,
      ST_SLEEP = 5'h02,
      ST_WAKE = 5'h04,
      ST_STALL = 5'h08,
      ST_IDLE = 5'h10
   } pm_state_e;
endpackage

// ===== logic/power_save_wdt_control.sv
// power-save, watchdog and supervision control of the processor core
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1 - watchdog enable taken from fuse bit
// R2 - watchdog overflow in run mode resets device
// R3 - clear instruction restarts watchdog count
// R4 - fuse zero lets software enable bit rule
// R5 - overflow in sleep wakes, sets both flags
// R6 - four-bit level field selects detect threshold
// R7 - enable bit and bandgap stable status bit
// R8 - sleep gates cpu, peripherals and oscillator
// R9 - monitor off in sleep, slow rc follows watchdog
// R10 - brown-out and low-voltage detect stay active
// R11 - interrupt, reset or overflow ends sleep
// R12 - restart previous clock, fuses after brown-out
// R13 - crystal waits start-up, pll waits lock
// R14 - rc or external clock: reset delay only
// R15 - running low-power crystal: reset delay only
// R16 - dead crystal: trap to fast rc or stall
// R17 - interrupt wake services handler, sets sleep flag
// R18 - non power-on resets wake and set sleep flag
// R19 - idle stops only cpu clock
// R20 - idle wake resumes at once, same sources
// R21 - idle flag set by wake or reset
// R22 - config words read back, low sixteen bits
// R23 - power-save operand: zero sleep, one idle
module power_save_wdt_control #(
   parameter int POWERUP_CYC = pm_pkg::POWERUP_CYC,
   parameter logic [pm_pkg::WDOG_W-1:0] WDOG_TOP = pm_pkg::WDOG_TOP_DEF
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // instruction events from the cpu
   input wire logic power_save_instr,
   input wire logic power_save_mode,
   input wire logic wdt_clear_instr,
   // reset control register port
   input wire logic reg_we,
   input wire logic [pm_pkg::REG_W-1:0] reg_wdata,
   output logic [pm_pkg::REG_W-1:0] reg_rdata,
   // configuration word table read
   input wire logic tbl_rd,
   input wire logic [pm_pkg::CFG_W-1:0] tbl_addr,
   output logic [pm_pkg::CFG_W-1:0] tbl_rdata,
   output logic tbl_valid,
   // fuse words
   input wire logic [pm_pkg::CFG_W-1:0] cfg_osc_word,
   input wire logic [pm_pkg::CFG_W-1:0] cfg_wdog_word,
   input wire logic [pm_pkg::CFG_W-1:0] cfg_brownout_word,
   input wire logic [pm_pkg::CFG_W-1:0] cfg_codeseg_word,
   // wake sources
   input wire logic int_wake_req,
   input wire logic brownout_event,
   input wire logic ext_reset_event,
   input wire logic sw_reset_event,
   // oscillator side
   input wire logic [1:0] current_osc_sel,
   input wire logic lowxtal_kept_on,
   input wire logic osc_startup_done,
   input wire logic pll_locked,
   input wire logic osc_running,
   input wire logic bandgap_ready,
   // clock and supervisor controls
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_run_en,
   output logic slowrc_run_en,
   output logic clkmon_active,
   output logic brownout_active,
   output logic lowv_active,
   output logic [pm_pkg::LEVEL_W-1:0] lowv_level,
   output logic [1:0] osc_restart_sel,
   // cpu controls
   output logic clock_fail_trap,
   output logic cpu_resume,
   output logic resume_to_isr,
   output logic wdog_device_reset
);
   typedef struct packed {
      pm_pkg::pm_state_e st;
      logic wdt_soft_enable;
      logic [pm_pkg::LEVEL_W-1:0] lvd_level_sel;
      logic lvd_enable;
      logic wdt_timeout_flag;
      logic sleep_flag;
      logic idle_flag;
      logic [pm_pkg::SYNC_N-1:0] s1;
      logic [pm_pkg::SYNC_N-1:0] s2;
      logic [pm_pkg::SYNC_N-1:0] s3;
      logic [pm_pkg::SYNC_N-1:0] filt;
      logic int_wake;
      logic dly_start;
      logic dly_powerup;
      logic dly_pll;
      logic dly_xtal;
      logic cpu_clk;
      logic periph_clk;
      logic osc_run;
      logic slowrc;
      logic clkmon;
      logic brownout;
      logic lowv;
      logic [1:0] osc_sel;
      logic trap;
      logic resume;
      logic resume_isr;
      logic wdog_rst;
      logic [pm_pkg::REG_W-1:0] rdata;
      logic [pm_pkg::CFG_W-1:0] tdata;
      logic tvalid;
   } ctl_s;
   ctl_s r;
   ctl_s n;

   pm_link_if lk();

   logic [pm_pkg::SYNC_N-1:0] async_in;
   logic wdog_fuse;
   logic wdog_on;
   logic clkmon_en;
   logic any_reset;
   logic wake_any;
   logic [1:0] wake_src;
   logic [3:0] primode;
   logic is_pri;
   logic is_lowx;
   logic w_xtal;
   logic w_pll;
   logic [pm_pkg::CFG_W-1:0] tword;

   assign async_in = {bandgap_ready, osc_running, pll_locked,
      osc_startup_done};
   assign wdog_fuse = cfg_wdog_word[pm_pkg::F_WDOG_EN];
   assign wdog_on = wdog_fuse || r.wdt_soft_enable; // R1 R4
   assign clkmon_en = cfg_osc_word[pm_pkg::F_CLKMON];
   assign any_reset = brownout_event || ext_reset_event || sw_reset_event;
   assign wake_any = int_wake_req || any_reset || lk.wdog_ovf; // R11 R20
   // after brown-out or without switching the fuses name the source
   assign wake_src = (brownout_event || !cfg_osc_word[pm_pkg::F_CLKSW]) ?
      cfg_osc_word[pm_pkg::F_FAMILY_LO +: 2] : current_osc_sel; // R12
   assign primode = cfg_osc_word[pm_pkg::F_PRIMODE_LO +: 4];
   assign is_pri = wake_src == pm_pkg::SRC_PRIMARY;
   assign is_lowx = wake_src == pm_pkg::SRC_LOWXTAL;
   assign w_xtal = (is_pri && primode[3:2] != pm_pkg::PRIMODE_EXT) ||
      (is_lowx && !lowxtal_kept_on); // R14 R15
   assign w_pll = is_pri && primode[3];

   assign lk.wdog_enable = wdog_on;
   assign lk.wdog_clear = wdt_clear_instr; // R3
   assign lk.dly_start = r.dly_start;
   assign lk.dly_powerup = r.dly_powerup;
   assign lk.dly_pll = r.dly_pll;
   assign lk.dly_xtal = r.dly_xtal;
   assign lk.startup_ok = r.filt[pm_pkg::S_STARTUP];
   assign lk.lock_ok = r.filt[pm_pkg::S_LOCK];

   wdog_counter #(.WDOG_TOP(WDOG_TOP)) u_wdog (
      .mclk(mclk),
      .resetn(resetn),
      .lk(lk.wdog)
   );

   wake_delay #(.POWERUP_CYC(POWERUP_CYC)) u_delay (
      .mclk(mclk),
      .resetn(resetn),
      .lk(lk.dly)
   );

   always_comb begin
      case (tbl_addr)
         pm_pkg::ADDR_OSC_CFG: tword = cfg_osc_word;
         pm_pkg::ADDR_WDOG_CFG: tword = cfg_wdog_word;
         pm_pkg::ADDR_BROWNOUT_CFG: tword = cfg_brownout_word;
         pm_pkg::ADDR_CODESEG_CFG: tword = cfg_codeseg_word;
         default: tword = '0;
      endcase
   end

   always_comb begin
      n = r;
      n.dly_start = 1'b0;
      n.trap = 1'b0;
      n.resume = 1'b0;
      n.resume_isr = 1'b0;
      n.wdog_rst = 1'b0;
      n.tvalid = tbl_rd;
      n.tdata = tbl_rd ? (tword & pm_pkg::CFG_MASK) : r.tdata; // R22
      n.s1 = async_in;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.filt = (r.s3 & ~(r.s2 ^ r.s3)) | (r.filt & (r.s2 ^ r.s3));
      if (reg_we) begin
         n.wdt_soft_enable = reg_wdata[pm_pkg::B_SOFT_EN]; // R4
         n.lvd_level_sel =
            reg_wdata[pm_pkg::B_LEVEL_LO +: pm_pkg::LEVEL_W]; // R6
         n.lvd_enable = reg_wdata[pm_pkg::B_DET_EN]; // R7
         n.wdt_timeout_flag = reg_wdata[pm_pkg::B_TIMEOUT];
         n.sleep_flag = reg_wdata[pm_pkg::B_SLEEP];
         n.idle_flag = reg_wdata[pm_pkg::B_IDLE];
      end
      case (r.st)
         pm_pkg::ST_RUN: begin
            if (lk.wdog_ovf) begin
               n.wdog_rst = 1'b1; // R2
               n.wdt_timeout_flag = 1'b1;
            end else if (power_save_instr) begin
               n.st = (power_save_mode == pm_pkg::MODE_SLEEP) ?
                  pm_pkg::ST_SLEEP : pm_pkg::ST_IDLE; // R23
            end
         end
         pm_pkg::ST_SLEEP: begin
            if (wake_any) begin
               n.sleep_flag = 1'b1; // R5 R17 R18
               if (lk.wdog_ovf) begin
                  n.wdt_timeout_flag = 1'b1; // R5
               end
               n.int_wake = int_wake_req && !any_reset && !lk.wdog_ovf;
               n.osc_sel = wake_src; // R12
               n.dly_start = 1'b1;
               n.dly_xtal = w_xtal; // R13
               n.dly_pll = w_pll;
               n.dly_powerup = w_xtal &&
                  cfg_brownout_word[pm_pkg::F_POWERUP_EN]; // R15
               n.st = pm_pkg::ST_WAKE;
            end
         end
         pm_pkg::ST_WAKE: begin
            if (lk.dly_done) begin
               if (r.filt[pm_pkg::S_RUNNING]) begin
                  n.st = pm_pkg::ST_RUN;
                  n.resume = 1'b1;
                  n.resume_isr = r.int_wake; // R17
               end else if (clkmon_en) begin
                  n.trap = 1'b1; // R16
                  n.osc_sel = pm_pkg::SRC_FASTRC;
                  n.st = pm_pkg::ST_RUN;
                  n.resume = 1'b1;
               end else begin
                  n.st = pm_pkg::ST_STALL; // R16
               end
            end
         end
         pm_pkg::ST_STALL: begin
            if (r.filt[pm_pkg::S_RUNNING]) begin
               n.st = pm_pkg::ST_RUN;
               n.resume = 1'b1;
               n.resume_isr = r.int_wake;
            end
         end
         pm_pkg::ST_IDLE: begin
            if (wake_any) begin
               n.idle_flag = 1'b1; // R21
               if (lk.wdog_ovf) begin
                  n.wdt_timeout_flag = 1'b1;
               end
               n.st = pm_pkg::ST_RUN; // R20
               n.resume = 1'b1;
               n.resume_isr = int_wake_req && !any_reset && !lk.wdog_ovf;
            end
         end
         default: n.st = pm_pkg::ST_RUN;
      endcase
      n.cpu_clk = n.st == pm_pkg::ST_RUN; // R8 R19
      n.periph_clk = n.st == pm_pkg::ST_RUN || n.st == pm_pkg::ST_IDLE;
      n.osc_run = n.st != pm_pkg::ST_SLEEP; // R8
      n.clkmon = clkmon_en && n.periph_clk; // R9 R19
      n.slowrc = wdog_on || n.clkmon; // R9
      n.brownout = cfg_brownout_word[pm_pkg::F_BROWNOUT_EN]; // R10
      n.lowv = n.lvd_enable; // R7 R10
      n.rdata = '0;
      n.rdata[pm_pkg::B_IDLE] = n.idle_flag;
      n.rdata[pm_pkg::B_SLEEP] = n.sleep_flag;
      n.rdata[pm_pkg::B_TIMEOUT] = n.wdt_timeout_flag;
      n.rdata[pm_pkg::B_SOFT_EN] = n.wdt_soft_enable;
      n.rdata[pm_pkg::B_LEVEL_LO +: pm_pkg::LEVEL_W] = n.lvd_level_sel;
      n.rdata[pm_pkg::B_DET_EN] = n.lvd_enable;
      n.rdata[pm_pkg::B_BANDGAP] = r.filt[pm_pkg::S_BANDGAP]; // R7
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.st <= pm_pkg::ST_RUN;
         r.cpu_clk <= 1'b1;
         r.periph_clk <= 1'b1;
         r.osc_run <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign reg_rdata = r.rdata;
   assign tbl_rdata = r.tdata;
   assign tbl_valid = r.tvalid;
   assign cpu_clk_en = r.cpu_clk;
   assign periph_clk_en = r.periph_clk;
   assign osc_run_en = r.osc_run;
   assign slowrc_run_en = r.slowrc;
   assign clkmon_active = r.clkmon;
   assign brownout_active = r.brownout;
   assign lowv_active = r.lowv;
   assign lowv_level = r.lvd_level_sel; // R6
   assign osc_restart_sel = r.osc_sel;
   assign clock_fail_trap = r.trap;
   assign cpu_resume = r.resume;
   assign resume_to_isr = r.resume_isr;
   assign wdog_device_reset = r.wdog_rst;

   AST_FUSE_ENABLE: assert property (@(posedge mclk) disable iff (!resetn) // R1
      wdog_fuse |-> lk.wdog_enable)
      else $error("watchdog off while fuse set");
   AST_SOFT_ENABLE: assert property (@(posedge mclk) disable iff (!resetn) // R4
      reg_we && !wdog_fuse && !reg_wdata[pm_pkg::B_SOFT_EN]
      ##1 !wdog_fuse |-> !lk.wdog_enable)
      else $error("software could not turn watchdog off");
   AST_WDOG_RESET: assert property (@(posedge mclk) disable iff (!resetn) // R2
      r.st == pm_pkg::ST_RUN && lk.wdog_ovf
      |=> wdog_device_reset && reg_rdata[pm_pkg::B_TIMEOUT])
      else $error("overflow did not reset device");
   AST_SLEEP_WDOG_WAKE: assert property (@(posedge mclk) disable iff (!resetn) // R5
      r.st == pm_pkg::ST_SLEEP && lk.wdog_ovf |=> !wdog_device_reset &&
      r.st == pm_pkg::ST_WAKE && r.sleep_flag && r.wdt_timeout_flag)
      else $error("sleep overflow handled wrongly");
   AST_SLEEP_CLOCKS: assert property (@(posedge mclk) disable iff (!resetn) // R8
      r.st == pm_pkg::ST_SLEEP
      |-> !cpu_clk_en && !periph_clk_en && !osc_run_en && !clkmon_active)
      else $error("clocks running in sleep");
   AST_IDLE_CLOCKS: assert property (@(posedge mclk) disable iff (!resetn) // R19
      r.st == pm_pkg::ST_IDLE |-> !cpu_clk_en && periph_clk_en && osc_run_en)
      else $error("idle clock gating wrong");
   AST_IDLE_WAKE: assert property (@(posedge mclk) disable iff (!resetn) // R20
      r.st == pm_pkg::ST_IDLE && int_wake_req
      |=> cpu_clk_en && cpu_resume && r.idle_flag)
      else $error("idle wake not immediate");
   AST_DETECT_ENABLE: assert property (@(posedge mclk) disable iff (!resetn) // R7
      reg_we |=> lowv_active == $past(reg_wdata[pm_pkg::B_DET_EN]))
      else $error("detector enable not applied");
   AST_DEAD_XTAL: assert property (@(posedge mclk) disable iff (!resetn) // R16
      r.st == pm_pkg::ST_WAKE && lk.dly_done && !r.filt[pm_pkg::S_RUNNING]
      |=> clock_fail_trap == clkmon_en && cpu_clk_en == clkmon_en)
      else $error("dead clock handling wrong");
endmodule
`default_nettype wire

// ===== logic/wake_delay.sv
// wake-up delay timer: reset delay, optional power-up and lock delays
`timescale 1ns/10ps
`default_nettype none
module wake_delay #(
   parameter int POWERUP_CYC = pm_pkg::POWERUP_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // controller link
   pm_link_if.dly lk
);
   localparam int POR_LO = pm_pkg::POR_CYC;
   localparam int POR_HI = pm_pkg::POR_CYC + 2;
   typedef struct packed {
      logic [pm_pkg::DLY_W-1:0] cnt;
      logic busy;
      logic xtal;
      logic pll;
      logic done;
   } dl_s;
   dl_s r;
   dl_s n;

   always_comb begin
      n = r;
      n.done = 1'b0;
      if (lk.dly_start) begin
         n.busy = 1'b1;
         n.xtal = lk.dly_xtal;
         n.pll = lk.dly_pll;
         n.cnt = pm_pkg::DLY_W'(pm_pkg::POR_CYC // R14 R15
            + (lk.dly_powerup ? POWERUP_CYC : 0)
            + (lk.dly_pll ? pm_pkg::LOCK_CYC : 0)); // R13
      end else if (r.busy) begin
         if (r.cnt != '0) begin
            n.cnt = r.cnt - 1'b1;
         end else if ((!r.xtal || lk.startup_ok) &&
               (!r.pll || lk.lock_ok)) begin // R13
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign lk.dly_done = r.done;

   AST_RC_WAKE_DELAY: assert property (@(posedge mclk) disable iff (!resetn) // R14
      lk.dly_start && !lk.dly_powerup && !lk.dly_pll && !lk.dly_xtal
      |-> ##[POR_LO:POR_HI] lk.dly_done)
      else $error("short wake delay not honoured");
   AST_PLL_HOLD: assert property (@(posedge mclk) disable iff (!resetn) // R13
      r.busy && r.pll && !lk.lock_ok |=> !lk.dly_done)
      else $error("clock released before pll lock");
endmodule
`default_nettype wire

// ===== logic/wdog_counter.sv
// watchdog counter with clear and overflow pulse
`timescale 1ns/10ps
`default_nettype none
module wdog_counter #(
   parameter logic [pm_pkg::WDOG_W-1:0] WDOG_TOP = pm_pkg::WDOG_TOP_DEF
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // controller link
   pm_link_if.wdog lk
);
   typedef struct packed {
      logic [pm_pkg::WDOG_W-1:0] cnt;
      logic ovf;
   } wd_s;
   wd_s r;
   wd_s n;

   always_comb begin
      n = r;
      n.ovf = 1'b0;
      if (!lk.wdog_enable || lk.wdog_clear) begin
         n.cnt = '0;
      end else if (r.cnt == WDOG_TOP) begin
         n.cnt = '0;
         n.ovf = 1'b1;
      end else begin
         n.cnt = r.cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign lk.wdog_ovf = r.ovf;

   AST_WDOG_CLEAR: assert property (@(posedge mclk) disable iff (!resetn) // R3
      lk.wdog_clear |=> r.cnt == '0 && !lk.wdog_ovf ##1 r.cnt <= 1)
      else $error("watchdog count not restarted by clear");
endmodule
`default_nettype wire

// ===== verification/osc_model.sv
// oscillator, pll and bandgap model on the far side of the controller
`timescale 1ns/10ps
`default_nettype none
module osc_model (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // control from the controller
   input wire logic osc_run_en,
   // stimulus: crystal never comes up although it reports started
   input wire logic osc_dead,
   // status to the controller
   output logic osc_startup_done,
   output logic pll_locked,
   output logic osc_running,
   output logic bandgap_ready
);
   logic [7:0] run_r;
   logic [7:0] bg_r;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         run_r <= 8'h00;
         bg_r <= 8'h00;
      end else begin
         run_r <= osc_run_en ? run_r + {7'h00, run_r != 8'hff} : 8'h00;
         bg_r <= bg_r + {7'h00, bg_r != 8'hff};
      end
   end
   // the oscillator dies on the first clock edge after its enable drops
   assign osc_running = !osc_dead && run_r > 8'h03;
   assign osc_startup_done = run_r > 8'h08;
   assign pll_locked = run_r > 8'h10;
   assign bandgap_ready = bg_r > 8'h64;
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// self-checking testbench of the power-save and watchdog control
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam logic [15:0] CLR = 16'h1a00;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic ps_instr = 1'b0, ps_mode = 1'b0, wclr = 1'b0, reg_we = 1'b0;
   logic tbl_rd = 1'b0, int_wake = 1'b0, ext_rst = 1'b0, sw_rst = 1'b0;
   logic bo_ev = 1'b0, isr_seen, trap_seen, lx_on = 1'b0, osc_dead = 1'b0;
   logic slowrc_run_en, brownout_active, clock_fail_trap;
   logic [1:0] osc_restart_sel, cur_osc = 2'h2;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic [23:0] tbl_addr = 24'h000000, tbl_rdata;
   logic [23:0] cfg_osc = 24'hab0200, cfg_wdog = 24'h5a0100;
   logic [23:0] cfg_bo = 24'hff00a0, cfg_cs = 24'hc31234;
   logic tbl_valid, cpu_clk_en, periph_clk_en, osc_run_en, clkmon_active;
   logic lowv_active, cpu_resume, resume_to_isr, wdog_device_reset;
   logic osc_startup_done, pll_locked, osc_running, bandgap_ready;
   logic [3:0] lowv_level;
   int failures = 0, samples_checked = 0, rst_seen = 0;

   always #25 mclk = ~mclk;
   always @(posedge wdog_device_reset) rst_seen++;

   power_save_wdt_control #(.POWERUP_CYC(50), .WDOG_TOP(16'h0040)) dut (
      .mclk(mclk), .resetn(resetn), .power_save_instr(ps_instr),
      .power_save_mode(ps_mode), .wdt_clear_instr(wclr), .reg_we(reg_we),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tbl_rd(tbl_rd),
      .tbl_addr(tbl_addr), .tbl_rdata(tbl_rdata), .tbl_valid(tbl_valid),
      .cfg_osc_word(cfg_osc), .cfg_wdog_word(cfg_wdog),
      .cfg_brownout_word(cfg_bo), .cfg_codeseg_word(cfg_cs),
      .int_wake_req(int_wake), .brownout_event(bo_ev),
      .ext_reset_event(ext_rst), .sw_reset_event(sw_rst),
      .current_osc_sel(cur_osc), .lowxtal_kept_on(lx_on),
      .osc_startup_done(osc_startup_done), .pll_locked(pll_locked),
      .osc_running(osc_running), .bandgap_ready(bandgap_ready),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .osc_run_en(osc_run_en), .slowrc_run_en(slowrc_run_en),
      .clkmon_active(clkmon_active), .brownout_active(brownout_active),
      .lowv_active(lowv_active), .lowv_level(lowv_level),
      .osc_restart_sel(osc_restart_sel), .clock_fail_trap(clock_fail_trap),
      .cpu_resume(cpu_resume),
      .resume_to_isr(resume_to_isr), .wdog_device_reset(wdog_device_reset));

   osc_model far (.mclk(mclk), .resetn(resetn), .osc_run_en(osc_run_en),
      .osc_dead(osc_dead),
      .osc_startup_done(osc_startup_done), .pll_locked(pll_locked),
      .osc_running(osc_running), .bandgap_ready(bandgap_ready));

   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] v);
      @(posedge mclk);
      reg_we <= 1'b1;
      reg_wdata <= v;
      @(posedge mclk);
      reg_we <= 1'b0;
      @(negedge mclk);
   endtask
   task automatic enter(input logic mode);
      @(posedge mclk);
      ps_instr <= 1'b1;
      ps_mode <= mode;
      @(posedge mclk);
      ps_instr <= 1'b0;
      @(negedge mclk);
   endtask
   task automatic wait_resume(output int c);
      c = 0;
      while (cpu_resume !== 1'b1 && c < 2000) begin
         @(negedge mclk);
         c++;
      end
      isr_seen = resume_to_isr;
      trap_seen = clock_fail_trap;
   endtask
   task automatic wait_wdog(output int c);
      int s;
      s = rst_seen;
      c = 0;
      while (rst_seen == s && c < 200) begin
         @(negedge mclk);
         c++;
      end
   endtask

   task automatic t_reset_reg;
      cmp({8'h00, reg_rdata}, 24'h000000);
      cmp({21'h0, cpu_clk_en, periph_clk_en, osc_run_en}, 24'h7);
      wr(16'h2000);
      cmp({8'h00, reg_rdata}, 24'h000000);
      repeat (120) @(negedge mclk);
      wr(CLR);
      cmp({8'h00, reg_rdata}, 24'h003a00);
      cmp({19'h0, lowv_active, lowv_level}, 24'h00001a);
   endtask
   task automatic t_table;
      logic [23:0] a[5] = '{24'hf80000, 24'hf80002, 24'hf80004,
         24'hf8000a, 24'hf80006};
      logic [23:0] w[5];
      w = '{cfg_osc, cfg_wdog, cfg_bo, cfg_cs, 24'h000000};
      for (int i = 0; i < 5; i++) begin
         @(posedge mclk);
         tbl_rd <= 1'b1;
         tbl_addr <= a[i];
         @(posedge mclk);
         tbl_rd <= 1'b0;
         @(negedge mclk);
         cmp({23'h0, tbl_valid}, 24'h000001);
         cmp(tbl_rdata, w[i] & 24'h00ffff);
      end
   endtask
   task automatic t_idle;
      int c;
      enter(1'b1);
      cmp({21'h0, cpu_clk_en, periph_clk_en, osc_run_en}, 24'h3);
      @(posedge mclk);
      int_wake <= 1'b1;
      @(negedge mclk);
      wait_resume(c);
      cmp({22'h0, c <= 2, isr_seen}, 24'h000003);
      @(posedge mclk);
      int_wake <= 1'b0;
      @(negedge mclk);
      cmp({8'h00, reg_rdata}, 24'h003a04);
      wr(CLR);
   endtask
   // src: 0 pin reset, 1 interrupt, 2 watchdog, 3 soft reset, 4 brown-out
   task automatic t_sleep(input int src, input logic [1:0] sel);
      int c, s;
      if (src == 2) wr(CLR | 16'h0020);
      s = rst_seen;
      enter(1'b0);
      cmp({17'h0, brownout_active, slowrc_run_en, cpu_clk_en, periph_clk_en,
         osc_run_en, clkmon_active, lowv_active},
         {17'h0, 1'b1, src == 2, 5'h01});
      @(posedge mclk);
      ext_rst <= (src == 0);
      int_wake <= (src == 1);
      sw_rst <= (src == 3);
      bo_ev <= (src == 4);
      @(posedge mclk);
      {ext_rst, sw_rst, bo_ev} <= 3'b000;
      wait_resume(c);
      if (src != 2) cmp({23'h0, c >= 200 && c < 260}, 24'h1);
      cmp({22'h0, isr_seen, trap_seen}, {22'h0, src == 1, 1'b0});
      cmp(24'(rst_seen - s), 24'h000000);
      cmp({22'h0, osc_restart_sel}, {22'h0, sel});
      @(posedge mclk);
      int_wake <= 1'b0;
      @(negedge mclk);
      cmp({8'h00, reg_rdata}, src == 2 ? 24'h003a38 : 24'h003a08);
      wr(CLR);
   endtask
   // clock switching picks the running source, brown-out the fuses
   task automatic t_switch;
      @(posedge mclk);
      cfg_osc <= 24'hab4200;
      cur_osc <= 2'h1;
      t_sleep(1, 2'h1);
      t_sleep(4, 2'h2);
      @(posedge mclk);
      cfg_osc <= 24'hab0000;
      lx_on <= 1'b1;
      t_sleep(1, 2'h0);
      @(posedge mclk);
      cfg_osc <= 24'hab0200;
      lx_on <= 1'b0;
   endtask
   // pll crystal with monitor on: full delays, then trap to fast rc
   task automatic t_trap;
      int c;
      @(posedge mclk);
      cfg_osc <= 24'hab8308;
      osc_dead <= 1'b1;
      enter(1'b0);
      @(posedge mclk);
      int_wake <= 1'b1;
      wait_resume(c);
      cmp({22'h0, c >= 650 && c < 700, trap_seen}, 24'h3);
      cmp({22'h0, osc_restart_sel}, 24'h000001);
      @(posedge mclk);
      int_wake <= 1'b0;
      cfg_osc <= 24'hab0200;
      osc_dead <= 1'b0;
      wr(CLR);
   endtask
   task automatic t_wdog;
      int c, s;
      wr(CLR | 16'h0020);
      wait_wdog(c);
      cmp({23'h0, c < 70}, 24'h000001);
      @(negedge mclk);
      cmp({8'h00, reg_rdata}, 24'h003a30);
      wr(CLR);
      s = rst_seen;
      repeat (150) @(negedge mclk);
      cmp(24'(rst_seen - s), 24'h000000);
      @(posedge mclk);
      cfg_wdog <= 24'h5a0180;
      wait_wdog(c);
      cmp({23'h0, c < 70}, 24'h000001);
      s = rst_seen;
      repeat (6) begin
         repeat (30) @(posedge mclk);
         wclr <= 1'b1;
         @(posedge mclk);
         wclr <= 1'b0;
      end
      cmp(24'(rst_seen - s), 24'h000000);
      cfg_wdog <= 24'h5a0100;
      wr(CLR);
   endtask

   task automatic report_and_stop;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      @(negedge mclk);
      t_reset_reg();
      t_table();
      t_idle();
      for (int i = 0; i < 5; i++) t_sleep(i, 2'h2);
      t_switch();
      t_trap();
      t_wdog();
      report_and_stop();
   end
   initial begin
      #500000;
      failures++;
      report_and_stop();
   end
endmodule
`default_nettype wire
